// [design/blp_ctrl.sv]
// Gate drive, light-load optimisation and input/output fault supervision of a buck stage.
// Assumes analog comparators on the power stage and a compensator on the same clock.
`timescale 1ns/1ps

// Summary of operation
// - High and low gates are never on together; a dead interval always separates them.
// - Dead time is trimmed once every 16 switching periods while running, to drive the loop duty to its minimum.
// - Diode emulation ends the low-side pulse at inductor zero crossing.
// - Diode emulation only on single phase or a group shed to one phase.
// - Adaptive frequency needs misc bit 0 set and diode emulation active.
// - Frequency stays programmed above half nominal duty, then falls linearly.
// - Reduced frequency moves in discrete steps between programmed and minimum.
// - Adaptive frequency blocked in sharing group, auto sync with clock, or clock out.
// - Strap decode: low 3 V, open 4.5 V, high 10.8 V.
// - Programmed undervoltage threshold 2.85 V to 16 V overrides the strap.
// - Undervoltage response: ignore, run then latch off, or shut with retries.
// - Default undervoltage response shuts down and restarts once the fault clears.
// - Overvoltage drops power good at once; default limit 15 percent over target.
// - Overvoltage response: shut with retries, or high off and low held on.
// - Default overvoltage response shuts down and restarts once the fault clears.
// - With an external clock a low-side hold request for overvoltage becomes shutdown with retries.
module blp_ctrl
  import blp_pkg::*;
#(
  parameter int DELAY_CYC = RESTART_DELAY_CYC
) (
  // Clock, reset, enable
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic CE_I,
  // Register port
  input wire logic [AW-1:0] ADDR_I,
  input wire logic [DW-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [DW-1:0] RDATA_O,
  // Power stage comparators and strap sensing (asynchronous)
  input wire logic STRAP_LOW_I,
  input wire logic STRAP_HIGH_I,
  input wire logic INPUT_UV_CMP_I,
  input wire logic OUTPUT_OV_CMP_I,
  input wire logic ZERO_CROSS_I,
  input wire logic EXT_CLK_PRESENT_I,
  // Loop and phase management (same clock)
  input wire logic [DW-1:0] DUTY_I,
  input wire logic [DW-1:0] NOM_DUTY_I,
  input wire logic SHARE_GROUP_I,
  input wire logic ONE_PHASE_LEFT_I,
  // Gate drives and status
  output logic HIGH_SIDE_GATE_O,
  output logic LOW_SIDE_GATE_O,
  output logic POWER_GOOD_OUT_O,
  output logic SYNC_DRIVE_O,
  output logic [10:0] UV_THRESHOLD_O,
  output logic [5:0] OV_MARGIN_O
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [5:0] pins_s;
  logic strap_lo_s, strap_hi_s, uv_s, ov_s, zc_s, ext_s;

  blp_sync2 #(.W(6)) u_sync (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .d_i({STRAP_LOW_I, STRAP_HIGH_I, INPUT_UV_CMP_I, OUTPUT_OV_CMP_I, ZERO_CROSS_I,
          EXT_CLK_PRESENT_I}),
    .q_o(pins_s)
  );
  assign {strap_lo_s, strap_hi_s, uv_s, ov_s, zc_s, ext_s} = pins_s;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [DW-1:0] ctrl, misc, freq, fmin, uvth, uvrsp, ovrsp, ovmg;
  logic [10:0] strap_thr;
  logic [1:0] strap_wait;
  logic strap_done;
  logic [3:0] dead_time;

  wire wr_ctrl = WR_I && (ADDR_I == REG_CTRL);
  wire restart = wr_ctrl && WDATA_I[CTRL_RESTART];
  wire [10:0] wr_uv = WDATA_I[10:0];
  // Clamp into the legal window; zero still means use the strap
  wire [10:0] uv_clamped = (wr_uv == 11'h000) ? 11'h000 :
                           (wr_uv < UV_PROG_MIN) ? UV_PROG_MIN :
                           (wr_uv > UV_PROG_MAX) ? UV_PROG_MAX : wr_uv;

  // Register writes; restart is a pulse and is not stored
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      ctrl <= CTRL_RST;
      misc <= MISC_RST;
      freq <= FREQ_RST;
      fmin <= FMIN_RST;
      uvth <= UVTH_RST;
      uvrsp <= RSP_RST;
      ovrsp <= RSP_RST;
      ovmg <= OVMG_RST;
    end else if (CE_I && WR_I) begin
      case (ADDR_I)
        REG_CTRL: ctrl <= WDATA_I & 16'h000F;
        REG_MISC: misc <= WDATA_I;
        REG_FREQ: freq <= WDATA_I;
        REG_FMIN: fmin <= WDATA_I;
        REG_UVTH: uvth <= {5'h00, uv_clamped};
        REG_UVRSP: uvrsp <= WDATA_I & 16'h001F;
        REG_OVRSP: ovrsp <= WDATA_I & 16'h001F;
        REG_OVMG: ovmg <= WDATA_I & 16'h003F;
        default: ;
      endcase
    end
  end

  // Strap caught once, after the synchronisers have filled
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      strap_wait <= 2'h0;
      strap_done <= 1'b0;
      strap_thr <= UV_STRAP_OPEN;
    end else if (CE_I && !strap_done) begin
      strap_wait <= strap_wait + 2'h1;
      if (strap_wait == STRAP_WAIT) begin
        strap_done <= 1'b1;
        strap_thr <= strap_lo_s ? UV_STRAP_LOW : strap_hi_s ? UV_STRAP_HIGH
                                                            : UV_STRAP_OPEN;
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  wire blp_sync_t sync_mode = blp_sync_t'(ctrl[CTRL_SYNC +: 2]);
  wire auto_with_clk = (sync_mode == SYNC_AUTO) && ext_s;
  wire ext_clocking = (sync_mode == SYNC_EXT_IN) || auto_with_clk;
  wire de_active = ctrl[CTRL_DE] && (!SHARE_GROUP_I || ONE_PHASE_LEFT_I);
  wire af_active = misc[MISC_AF] && de_active && !SHARE_GROUP_I && !auto_with_clk &&
                   (sync_mode != SYNC_DRIVE_OUT);
  wire blp_fresp_t uv_mode = blp_fresp_t'(uvrsp[RSP_MODE +: 2]);
  wire blp_fresp_t ov_req = blp_fresp_t'(ovrsp[RSP_MODE +: 2]);
  // Low-side hold needs the internal clock; fall back to shutdown otherwise
  wire blp_fresp_t ov_mode = (ext_clocking && ov_req == RSP_LOW_HOLD) ? RSP_RETRY
                                                                      : ov_req;

  assign UV_THRESHOLD_O = (uvth[10:0] != 11'h000) ? uvth[10:0] : strap_thr;
  assign OV_MARGIN_O = ovmg[5:0];
  assign SYNC_DRIVE_O = (sync_mode == SYNC_DRIVE_OUT);

  // ----------------------------------------------------------------
  // Fault sequencers
  // ----------------------------------------------------------------
  logic uv_shut, uv_latch, ov_shut, ov_hold, ov_latch;

  blp_fault_seq #(.DELAY_CYC(DELAY_CYC)) u_uv (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .ce_i(CE_I),
    .fault_i(uv_s),
    .mode_i(uv_mode),
    .tries_i(uvrsp[RSP_TRY +: 3]),
    .restart_i(restart),
    .shut_o(uv_shut),
    .hold_o(),
    .latch_o(uv_latch)
  );

  blp_fault_seq #(.DELAY_CYC(DELAY_CYC)) u_ov (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .ce_i(CE_I),
    .fault_i(ov_s),
    .mode_i(ov_mode),
    .tries_i(ovrsp[RSP_TRY +: 3]),
    .restart_i(restart),
    .shut_o(ov_shut),
    .hold_o(ov_hold),
    .latch_o(ov_latch)
  );

  wire run_ok = ctrl[CTRL_RUN] && strap_done && !uv_shut && !ov_shut;

  // ----------------------------------------------------------------
  // Adaptive frequency
  // ----------------------------------------------------------------
  logic [DW-1:0] duty_lat;
  logic [AF_STEPS-1:0] thr_hit;
  logic [3:0] level;

  // Thermometer of duty against fractions of half the nominal duty
  generate
    for (genvar k = 1; k <= AF_STEPS; k++) begin : g_thr
      assign thr_hit[k-1] = ({duty_lat, 4'h0} >= (20'(NOM_DUTY_I) * 20'(k)));
    end
  endgenerate

  always_comb begin
    level = 4'h0;
    for (int i = 0; i < AF_STEPS; i++) begin
      level = level + {3'h0, thr_hit[i]};
    end
  end

  // Linear in frequency, quantised to eighths of the span
  wire [DW-1:0] f_span = (freq > fmin) ? freq - fmin : 16'h0000;
  wire [19:0] f_prod = 20'(f_span) * 20'(level);
  wire [DW-1:0] f_red = fmin + f_prod[18:3];
  wire [DW-1:0] f_word = af_active ? f_red : freq;

  // ----------------------------------------------------------------
  // Phase accumulator
  // ----------------------------------------------------------------
  logic [DW-1:0] phase;
  wire [DW:0] ph_sum = {1'b0, phase} + {1'b0, f_word};
  wire wrap = ph_sum[DW];
  wire hs_dem = run_ok && (phase < duty_lat);

  // Duty is taken once per period so the pulse never chops mid-cycle
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      phase <= 16'h0000;
      duty_lat <= 16'h0000;
    end else if (CE_I) begin
      phase <= ph_sum[DW-1:0];
      if (wrap) duty_lat <= DUTY_I;
    end
  end

  // ----------------------------------------------------------------
  // Dead-time adjuster
  // ----------------------------------------------------------------
  logic [3:0] adj_cnt;
  logic [DW-1:0] duty_ref;
  logic adj_up;
  wire adj_now = wrap && run_ok && (adj_cnt == ADJ_LAST);
  wire next_dir = (duty_lat > duty_ref) ? !adj_up : adj_up;

  // Perturb and observe: keep stepping while duty falls, turn back when it rises
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      adj_cnt <= 4'h0;
      duty_ref <= 16'h0000;
      adj_up <= 1'b0;
      dead_time <= DT_RST;
    end else if (CE_I) begin
      if (wrap && run_ok) adj_cnt <= adj_cnt + 4'h1;
      if (adj_now) begin
        duty_ref <= duty_lat;
        adj_up <= next_dir;
        if (next_dir && dead_time != DT_MAX) dead_time <= dead_time + 4'h1;
        else if (!next_dir && dead_time != DT_MIN) dead_time <= dead_time - 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Gate sequencer
  // ----------------------------------------------------------------
  blp_gate_t gst;
  blp_gate_t next_gst;
  logic [3:0] dcnt;
  wire dead_done = (dcnt == 4'h0);

  always_comb begin
    next_gst = gst;
    case (gst)
      GS_IDLE: begin
        if (hs_dem) next_gst = GS_DEAD_HS;
        else if (ov_hold) next_gst = GS_DEAD_LS;
      end
      GS_DEAD_HS: begin
        if (!run_ok) next_gst = GS_IDLE;
        else if (dead_done) next_gst = GS_HS;
      end
      GS_HS: begin
        if (!hs_dem) next_gst = GS_DEAD_LS;
      end
      GS_DEAD_LS: begin
        if (dead_done) next_gst = (run_ok || ov_hold) ? GS_LS : GS_IDLE;
      end
      GS_LS: begin
        if (ov_hold) next_gst = GS_LS;
        else if (!run_ok) next_gst = GS_IDLE;
        else if (hs_dem) next_gst = GS_DEAD_HS;
        else if (de_active && zc_s) next_gst = GS_IDLE;
      end
      default: next_gst = GS_IDLE;
    endcase
  end

  // Both gates come from one state code, so overlap cannot occur
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      gst <= GS_IDLE;
      dcnt <= 4'h0;
      HIGH_SIDE_GATE_O <= 1'b0;
      LOW_SIDE_GATE_O <= 1'b0;
    end else if (CE_I) begin
      gst <= next_gst;
      dcnt <= (next_gst != gst) ? dead_time : (dead_done ? 4'h0 : dcnt - 4'h1);
      HIGH_SIDE_GATE_O <= (next_gst == GS_HS);
      LOW_SIDE_GATE_O <= (next_gst == GS_LS);
    end
  end

  // ----------------------------------------------------------------
  // Power good and read port
  // ----------------------------------------------------------------
  wire [DW-1:0] status = {4'h0, dead_time, ov_hold, POWER_GOOD_OUT_O, af_active, de_active,
                          ov_latch, uv_latch, ov_s, uv_s};
  wire [DW-1:0] rd_mux = (ADDR_I == REG_CTRL) ? ctrl :
                         (ADDR_I == REG_MISC) ? misc :
                         (ADDR_I == REG_FREQ) ? freq :
                         (ADDR_I == REG_FMIN) ? fmin :
                         (ADDR_I == REG_UVTH) ? uvth :
                         (ADDR_I == REG_UVRSP) ? uvrsp :
                         (ADDR_I == REG_OVRSP) ? ovrsp :
                         (ADDR_I == REG_OVMG) ? ovmg :
                         (ADDR_I == REG_STAT) ? status : 16'h0000;

  // Power good drops the cycle after a synchronised overvoltage
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      POWER_GOOD_OUT_O <= 1'b0;
      RDATA_O <= 16'h0000;
    end else if (CE_I) begin
      POWER_GOOD_OUT_O <= run_ok && !ov_s;
      RDATA_O <= RD_I ? rd_mux : 16'h0000;
    end
  end

endmodule

// [design/blp_fault_seq.sv]
// Fault response sequencer shared by the undervoltage and overvoltage paths.
// Assumes a synchronised fault level and a restart pulse from the same clock.
`timescale 1ns/1ps
module blp_fault_seq
  import blp_pkg::*;
#(
  parameter int DELAY_CYC = RESTART_DELAY_CYC
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic fault_i,
  input wire blp_fresp_t mode_i,
  input wire logic [2:0] tries_i,
  input wire logic restart_i,
  output logic shut_o,
  output logic hold_o,
  output logic latch_o
);

  localparam int CW = $clog2(DELAY_CYC + 1);
  localparam logic [CW-1:0] CNT_END = CW'(DELAY_CYC - 1);

  blp_fstate_t st;
  blp_fstate_t next_st;
  logic [CW-1:0] cnt;
  logic [2:0] tries;
  wire cnt_done = (cnt == CNT_END);
  wire infinite = (tries_i == TRY_INF);

  // Response selection, delay pacing and retry counting
  always_comb begin
    next_st = st;
    case (st)
      FS_RUN: begin
        if (fault_i) begin
          case (mode_i)
            RSP_DELAY_OFF: next_st = FS_GRACE;
            RSP_RETRY: next_st = (tries_i == 3'h0) ? FS_LATCH : FS_OFF;
            RSP_LOW_HOLD: next_st = FS_HOLD;
            default: next_st = FS_RUN;
          endcase
        end
      end
      FS_GRACE: begin
        if (!fault_i) next_st = FS_RUN;
        else if (cnt_done) next_st = FS_LATCH;
      end
      FS_OFF: begin
        if (cnt_done && !fault_i) next_st = FS_RUN;
        else if (cnt_done && !infinite && (tries + 3'h1 >= tries_i)) next_st = FS_LATCH;
      end
      FS_HOLD: begin
        if (cnt_done && !fault_i) next_st = FS_RUN;
      end
      FS_LATCH: begin
        if (restart_i) next_st = FS_RUN;
      end
      default: next_st = FS_RUN;
    endcase
  end

  // State, delay counter and attempt counter
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st <= FS_RUN;
      cnt <= '0;
      tries <= 3'h0;
    end else if (ce_i) begin
      st <= next_st;
      cnt <= (next_st != st || cnt_done) ? '0 : cnt + 1'b1;
      if (restart_i || (st == FS_RUN && cnt_done)) tries <= 3'h0;
      else if (st == FS_OFF && cnt_done && fault_i && !infinite) tries <= tries + 3'h1;
    end
  end

  assign shut_o = (st == FS_OFF) || (st == FS_LATCH) || (st == FS_HOLD);
  assign hold_o = (st == FS_HOLD);
  assign latch_o = (st == FS_LATCH);

endmodule

// [design/blp_sync2.sv]
// Two-flop synchroniser for a bundle of asynchronous level inputs.
// Assumes each bit is an independent slow level; no bus coherence is given.
`timescale 1ns/1ps
module blp_sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta;

  // First stage is read only by the second stage
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end

endmodule

// [shared/blp_pkg.sv]
// Constants, register map and encodings for the buck light-load and fault controller.
// Assumes a 250 MHz control clock and a 16-bit word-indexed register port.
package blp_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int RESTART_DELAY_US = 70; // Delay between restart attempts
  localparam int RESTART_DELAY_CYC = RESTART_DELAY_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Register map (word index)
  // ----------------------------------------------------------------
  localparam int DW = 16;
  localparam int AW = 4;
  localparam logic [AW-1:0] REG_CTRL = 4'h0;
  localparam logic [AW-1:0] REG_MISC = 4'h1;
  localparam logic [AW-1:0] REG_FREQ = 4'h2;
  localparam logic [AW-1:0] REG_FMIN = 4'h3;
  localparam logic [AW-1:0] REG_UVTH = 4'h4;
  localparam logic [AW-1:0] REG_UVRSP = 4'h5;
  localparam logic [AW-1:0] REG_OVRSP = 4'h6;
  localparam logic [AW-1:0] REG_OVMG = 4'h7;
  localparam logic [AW-1:0] REG_STAT = 4'h8;

  // Field positions
  localparam int CTRL_RUN = 0;
  localparam int CTRL_DE = 1;
  localparam int CTRL_SYNC = 2; // Two bits
  localparam int CTRL_RESTART = 4; // Write-one pulse
  localparam int MISC_AF = 0;
  localparam int RSP_MODE = 0; // Two bits
  localparam int RSP_TRY = 2; // Three bits

  // Reset values
  localparam logic [DW-1:0] CTRL_RST = 16'h0000;
  localparam logic [DW-1:0] MISC_RST = 16'h0000;
  localparam logic [DW-1:0] FREQ_RST = 16'h0069;
  localparam logic [DW-1:0] FMIN_RST = 16'h0035;
  localparam logic [DW-1:0] UVTH_RST = 16'h0000;
  localparam logic [DW-1:0] RSP_RST = 16'h001E;
  localparam logic [DW-1:0] OVMG_RST = 16'h000F;

  // Undervoltage thresholds in units of 10 mV
  localparam logic [10:0] UV_STRAP_LOW = 11'h12C;
  localparam logic [10:0] UV_STRAP_OPEN = 11'h1C2;
  localparam logic [10:0] UV_STRAP_HIGH = 11'h438;
  localparam logic [10:0] UV_PROG_MIN = 11'h11D;
  localparam logic [10:0] UV_PROG_MAX = 11'h640;

  // Dead time in clock cycles and adjuster pacing
  localparam logic [3:0] DT_MIN = 4'h1;
  localparam logic [3:0] DT_MAX = 4'hF;
  localparam logic [3:0] DT_RST = 4'h4;
  localparam logic [3:0] ADJ_LAST = 4'hF;
  localparam int AF_STEPS = 8;
  localparam logic [2:0] TRY_INF = 3'h7;
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RSP_IGNORE = 2'b00, RSP_DELAY_OFF = 2'b01, RSP_RETRY = 2'b10, RSP_LOW_HOLD = 2'b11
  } blp_fresp_t;
  typedef enum logic [1:0] {
    SYNC_INTERNAL = 2'b00, SYNC_AUTO = 2'b01, SYNC_EXT_IN = 2'b10, SYNC_DRIVE_OUT = 2'b11
  } blp_sync_t;
  typedef enum logic [2:0] {
    GS_IDLE = 3'b000, GS_DEAD_HS = 3'b001, GS_HS = 3'b010, GS_DEAD_LS = 3'b011,
    GS_LS = 3'b100
  } blp_gate_t;
  typedef enum logic [2:0] {
    FS_RUN = 3'b000, FS_GRACE = 3'b001, FS_OFF = 3'b010, FS_LATCH = 3'b011,
    FS_HOLD = 3'b100
  } blp_fstate_t;

endpackage

// [verification/blp_ctrl_asserts.sv]
// Port checker for blp_ctrl: gate spacing, read port, fault reactions.
// Assumes it is bound into blp_ctrl and sees only its ports.
`timescale 1ns/1ps
module blp_ctrl_asserts
  import blp_pkg::*;
#(
  parameter int DELAY_CYC = RESTART_DELAY_CYC
) (
  // Clock and register port
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic CE_I,
  input wire logic [AW-1:0] ADDR_I,
  input wire logic [DW-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [DW-1:0] RDATA_O,
  // Stage and status
  input wire logic OUTPUT_OV_CMP_I,
  input wire logic HIGH_SIDE_GATE_O,
  input wire logic LOW_SIDE_GATE_O,
  input wire logic POWER_GOOD_OUT_O,
  input wire logic SYNC_DRIVE_O,
  input wire logic [10:0] UV_THRESHOLD_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  // Two cycles with both gates low
  sequence both_low2;
    !HIGH_SIDE_GATE_O && !LOW_SIDE_GATE_O ##1 !HIGH_SIDE_GATE_O && !LOW_SIDE_GATE_O;
  endsequence
  // Overvoltage seen long enough to pass the synchroniser and sequencer
  sequence ov_held;
    OUTPUT_OV_CMP_I [*6];
  endsequence
  gates_apart_a: assert property (!(HIGH_SIDE_GATE_O && LOW_SIDE_GATE_O))
    else $error("both gates on");
  hs_dead_a: assert property ($fell(HIGH_SIDE_GATE_O) |-> both_low2)
    else $error("no dead gap after high side");
  ls_dead_a: assert property ($fell(LOW_SIDE_GATE_O) |-> both_low2)
    else $error("no dead gap after low side");
  pg_ov_a: assert property ($rose(OUTPUT_OV_CMP_I) |-> ##[0:3] !POWER_GOOD_OUT_O)
    else $error("power good kept during overvoltage");
  ov_hs_a: assert property (ov_held |-> !HIGH_SIDE_GATE_O)
    else $error("high side on during overvoltage");
  uv_range_a: assert property (UV_THRESHOLD_O >= UV_PROG_MIN && UV_THRESHOLD_O <= UV_PROG_MAX)
    else $error("threshold out of range");
  sync_drive_a: assert property ($past(WR_I && CE_I && ADDR_I == REG_CTRL) |->
    SYNC_DRIVE_O == ($past(WDATA_I[3:2]) == 2'h3))
    else $error("clock drive decode wrong");
  rd_idle_a: assert property (!$past(RD_I && CE_I) |-> RDATA_O == 16'h0000)
    else $error("read data outside its cycle");
  unmapped_a: assert property ($past(RD_I && CE_I && ADDR_I > REG_STAT) |-> RDATA_O == 16'h0000)
    else $error("unmapped read not zero");
  restart_rd_a: assert property ($past(RD_I && CE_I && ADDR_I == REG_CTRL) |->
    !RDATA_O[CTRL_RESTART])
    else $error("restart bit reads back");
  ov_seen_c: cover property (ov_held);
endmodule

bind blp_ctrl blp_ctrl_asserts #(.DELAY_CYC(DELAY_CYC)) u_asserts (.*);

// [verification/blp_ctrl_tb_top.sv]
// Self-checking bench for blp_ctrl: registers, strap, faults, light load.
// Assumes the stage model for zero crossing and a short restart delay.
`timescale 1ns/1ps
module blp_ctrl_tb_top;
  import blp_pkg::*;
  `define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin n_mismatch++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end
  typedef struct packed {logic [DW-1:0] v; logic [DW-1:0] m;} blp_note_t;
  logic clk = 0, rst = 1, ce = 1, wr = 0, rd = 0, rd_q = 0;
  logic [AW-1:0] addr = 4'h0;
  logic [DW-1:0] wdata = 16'h0000, duty = 16'h1000, rdata;
  logic s_lo = 0, s_hi = 0, uv = 0, ov = 0, ext = 0, share = 0, one = 0;
  logic hs, ls, pg, syncd, zc;
  logic [10:0] uvth;
  logic [5:0] ovmg;
  logic [15:0] ovl;
  int n_mismatch = 0, comparisons = 0, seed = 86;
  blp_note_t notes[$];
  blp_note_t nt;
  // Light-load table: ctrl, misc, share, one phase, ext clock, expected status bits 5:4
  logic [9:0] af_tab [7] = '{10'h0E3, 10'h0C1, 10'h060, 10'h0F0, 10'h0F9, 10'h1E5, 10'h3E1};
  always #2 clk = ~clk;
  // Duty stays under half of nominal so the light-load paths can engage
  always @(posedge clk) duty <= {4'h1, 12'($random(seed))};
  blp_ctrl #(.DELAY_CYC(8)) DUT (.CLK_I(clk), .RESET_I(rst), .CE_I(ce), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .STRAP_LOW_I(s_lo),
    .STRAP_HIGH_I(s_hi), .INPUT_UV_CMP_I(uv), .OUTPUT_OV_CMP_I(ov), .ZERO_CROSS_I(zc),
    .EXT_CLK_PRESENT_I(ext), .DUTY_I(duty), .NOM_DUTY_I(16'h8000), .SHARE_GROUP_I(share),
    .ONE_PHASE_LEFT_I(one), .HIGH_SIDE_GATE_O(hs), .LOW_SIDE_GATE_O(ls),
    .POWER_GOOD_OUT_O(pg), .SYNC_DRIVE_O(syncd), .UV_THRESHOLD_O(uvth), .OV_MARGIN_O(ovmg));
  blp_stage_model u_stage (.clk_i(clk), .hs_i(hs), .ls_i(ls), .zero_cross_o(zc),
    .overlap_o(ovl));
  // Read data stands one cycle after the strobe; match it against the oldest note
  always @(posedge clk) begin
    rd_q <= rd & ce;
    if (rd_q) begin
      nt = notes.pop_front();
      `CHK("rdata", nt.v, rdata & nt.m)
    end
  end
  // Called just after an edge; the trailing edge keeps a strobe from being set twice at once
  task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [AW-1:0] a, input logic [DW-1:0] e, input logic [DW-1:0] m);
    addr <= a;
    rd <= 1'b1;
    notes.push_back('{e & m, m});
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask
  // Counts high-side cycles; each 300- or 400-cycle window spans several switching periods
  task automatic pulses(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge clk);
      c += (hs === 1'b1);
    end
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Far beyond the expected run length
  initial begin
    #200000;
    n_mismatch++;
    close_out();
  end
  initial begin : main
    int c;
    for (int k = 0; k < 3; k++) begin
      s_lo <= (k == 0);
      s_hi <= (k == 1);
      do_reset();
      `CHK("strap", k == 0 ? UV_STRAP_LOW : k == 1 ? UV_STRAP_HIGH : UV_STRAP_OPEN, uvth)
    end
    rd_reg(REG_FREQ, FREQ_RST, 16'hFFFF);
    rd_reg(REG_FMIN, FMIN_RST, 16'hFFFF);
    rd_reg(REG_UVRSP, RSP_RST, 16'hFFFF);
    rd_reg(REG_OVRSP, RSP_RST, 16'hFFFF);
    rd_reg(REG_OVMG, OVMG_RST, 16'hFFFF);
    rd_reg(4'hF, 16'h0000, 16'hFFFF);
    `CHK("ov_margin", 6'h0F, ovmg)
    wr_reg(REG_UVTH, 16'h0100);
    rd_reg(REG_UVTH, {5'h00, UV_PROG_MIN}, 16'hFFFF);
    wr_reg(REG_UVTH, 16'h07D0);
    rd_reg(REG_UVTH, {5'h00, UV_PROG_MAX}, 16'hFFFF);
    wr_reg(REG_UVTH, 16'h0200);
    @(posedge clk);
    `CHK("uv_thr", 11'h200, uvth)
    wr_reg(REG_UVTH, 16'h0000);
    @(posedge clk);
    `CHK("uv_thr", UV_STRAP_OPEN, uvth)
    wr_reg(REG_FREQ, 16'h0400);
    wr_reg(REG_CTRL, 16'h0001);
    pulses(300, c);
    `CHK("hs_run", 1'b1, c > 0)
    ov <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK("pg", 1'b0, pg)
    rd_reg(REG_STAT, 16'h0002, 16'h0002);
    pulses(40, c);
    `CHK("hs_ov", 0, c)
    ov <= 1'b0;
    pulses(400, c);
    `CHK("hs_back", 1'b1, c > 0)
    `CHK("pg_back", 1'b1, pg)
    // Ignore keeps switching through an undervoltage
    wr_reg(REG_UVRSP, 16'h0000);
    uv <= 1'b1;
    pulses(300, c);
    `CHK("hs_uv_ign", 1'b1, c > 0)
    // Delay-then-off and zero retries both stay off until the restart pulse
    for (int k = 1; k < 3; k++) begin
      wr_reg(REG_UVRSP, 16'(k));
      uv <= 1'b1;
      repeat (50) @(posedge clk);
      uv <= 1'b0;
      pulses(300, c);
      `CHK("hs_latched", 0, c)
      rd_reg(REG_STAT, 16'h0004, 16'h0004);
      wr_reg(REG_CTRL, 16'h0011);
      pulses(400, c);
      `CHK("hs_restart", 1'b1, c > 0)
    end
    // Low-hold is refused on the external clock, honoured on the internal one
    wr_reg(REG_OVRSP, 16'h001F);
    for (int k = 0; k < 2; k++) begin
      ext <= (k == 0);
      wr_reg(REG_CTRL, k ? 16'h0001 : 16'h0009);
      ov <= 1'b1;
      repeat (20) @(posedge clk);
      rd_reg(REG_STAT, k ? 16'h0080 : 16'h0000, 16'h0080);
      `CHK("ls_hold", k[0], ls)
      ov <= 1'b0;
      pulses(400, c);
      `CHK("hs_rearm", 1'b1, c > 0)
    end
    foreach (af_tab[i]) begin
      share <= af_tab[i][4];
      one <= af_tab[i][3];
      ext <= af_tab[i][2];
      wr_reg(REG_MISC, {15'h0000, af_tab[i][5]});
      wr_reg(REG_CTRL, {12'h000, af_tab[i][9:6]});
      repeat (6) @(posedge clk);
      rd_reg(REG_STAT, {10'h000, af_tab[i][1:0], 4'h0}, 16'h0030);
    end
    wr_reg(REG_CTRL, 16'h0001);
    repeat (4) @(posedge clk);
    `CHK("overlap", 16'h0000, ovl)
    close_out();
  end
endmodule

// [verification/blp_stage_model.sv]
// Behavioural power stage: inductor current built from the gate drives.
// Assumes gates on the control clock; current in arbitrary units.
`timescale 1ns/1ps
module blp_stage_model (
  // Clock and gates
  input wire logic clk_i,
  input wire logic hs_i,
  input wire logic ls_i,
  // Sensing back to the controller
  output logic zero_cross_o,
  output logic [15:0] overlap_o
);
  int cur = 0;
  initial overlap_o = 16'h0000;
  // Ramp up on the high side; the low side may pull current negative, the diode conducts only while current is positive
  always @(posedge clk_i) begin
    if (hs_i)
      cur <= cur + 4;
    else if (ls_i || cur > 0)
      cur <= cur - 3;
    if (hs_i && ls_i)
      overlap_o <= overlap_o + 16'h0001;
  end
  // Comparator fires at or below zero, as the controller expects
  assign zero_cross_o = (cur <= 0);
endmodule
